// [test_two_thread_pipeline_sharing.sv]
// Self-checking bench for the two-thread sharing control.
// Assumes package default depths and the cache model on the fetch miss path.
`timescale 1ns/1ps
`default_nettype none
module test_two_thread_pipeline_sharing;
  localparam int unsigned L2_LAT = 5;
  logic                    clk_sys;
  logic                    nrst;
  logic                    slow;
  logic [1:0]              act;
  logic [1:0]              miss;
  logic [1:0]              rq [4];
  tps_pkg::tps_buf_ev_type ev [5];
  logic [15:0]             sched;
  logic [1:0]              viol;
  logic                    dfill;
  logic                    dftid;
  logic [19:0]             dvpn;
  logic                    ltid;
  logic [19:0]             lvpn;
  logic                    ctx;
  logic [1:0]              ipl;
  logic [31:0]             ipn;
  wire logic [1:0]         gn [4];
  wire logic [1:0]         room [5];
  wire logic [1:0]         fill;
  wire logic               ftid;
  wire logic               fvalid;
  wire logic [15:0]        sel;
  wire logic [2:0]         cnt;
  wire logic [1:0]         flush;
  wire logic               hit;
  wire logic               mode;
  wire logic [31:0]        ip0;
  wire logic [31:0]        ip1;
  int                      n_errors = 0;
  int                      compares = 0;
  int unsigned             dep [5] = '{tps_pkg::UOPQ_DEPTH, tps_pkg::RNQ_DEPTH, tps_pkg::ROB_DEPTH,
                                       tps_pkg::LDB_DEPTH, tps_pkg::STB_DEPTH};

  tps_core_ctl tps_core_ctl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .thread_active(act), .fetch_req(rq[0]), .fetch_miss(miss),
    .l2_fill_done(fill), .fetch_gnt(gn[0]), .fetch_tid_q(ftid), .fetch_valid_q(fvalid),
    .uopq_ev(ev[0]), .rnq_ev(ev[1]), .rob_ev(ev[2]), .ldb_ev(ev[3]), .stb_ev(ev[4]),
    .uopq_room(room[0]), .rnq_room(room[1]), .rob_room(room[2]), .ldb_room(room[3]),
    .stb_room(room[4]), .rename_req(rq[1]), .rename_gnt(gn[1]), .sched_ready(sched),
    .dispatch_sel_q(sel), .dispatch_cnt_q(cnt), .retire_ready(rq[2]), .retire_gnt(gn[2]),
    .stcommit_req(rq[3]), .stcommit_gnt(gn[3]), .mem_order_viol(viol), .order_flush_q(flush),
    .dtb_fill(dfill), .dtb_fill_tid(dftid), .dtb_fill_vpn(dvpn), .dtb_look_tid(ltid),
    .dtb_look_vpn(lvpn), .dtb_hit_q(hit), .ctx_id_bit(ctx), .cache_mode_q(mode),
    .ip_load(ipl), .ip_new(ipn), .ip0_q(ip0), .ip1_q(ip1)
  );

  tps_l2_model #(.LAT(L2_LAT)) tps_l2_model_inst (
    .clk_sys(clk_sys), .nrst(nrst), .slow(slow), .fetch_miss(miss), .l2_fill_done(fill)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic t_fetch_alt();
    @(negedge clk_sys);
    rq[0] = 2'h3;
    #1 chk(gn[0], 2'h1);
    @(negedge clk_sys);
    chk({fvalid, ftid}, 2'h2);
    #1 chk(gn[0], 2'h2);
    @(negedge clk_sys);
    chk({fvalid, ftid}, 2'h3);
    #1 chk(gn[0], 2'h1);
    @(negedge clk_sys);
    rq[0] = 2'h0;
  endtask : t_fetch_alt

  // Thread 0 misses; thread 1 owns fetch until the fill returns
  task automatic t_miss(input logic s);
    int unsigned lat;
    int          k;
    lat = s ? 3 * L2_LAT : L2_LAT;
    @(negedge clk_sys);
    slow = s;
    rq[0] = 2'h3;
    miss = 2'h1;
    for (k = 0; k < lat; k++) begin
      #1 chk(gn[0], 2'h2);
      @(negedge clk_sys);
      miss = 2'h0;
    end
    k = 0;
    #1;
    while (k < 8 && gn[0][0] !== 1'h1) begin
      @(negedge clk_sys);
      #1;
      k++;
    end
    chk(k < 8, 1'h1);
    @(negedge clk_sys);
    rq[0] = 2'h0;
  endtask : t_miss

  task automatic t_arb(input int i);
    logic [1:0] g1;
    @(negedge clk_sys);
    rq[i] = 2'h3;
    #1 g1 = gn[i];
    @(negedge clk_sys);
    #1 chk(g1 ^ gn[i], 2'h3);
    chk($countones(g1), 1);
    @(negedge clk_sys);
    rq[i] = 2'h2;
    for (int k = 0; k < 3; k++) begin
      #1 chk(gn[i], 2'h2);
      @(negedge clk_sys);
    end
    rq[i] = 2'h0;
  endtask : t_arb

  // Fill one thread to its cap, try one refused push, then drain it
  task automatic t_part(input int b, input int t, input int cap);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (room[b][t] === 1'h1 && n < 40) begin
      ev[b].push[t] = 1'h1;
      n++;
      @(negedge clk_sys);
    end
    chk(n, cap);
    chk(room[b][1-t], cap < dep[b]);
    @(negedge clk_sys);
    ev[b].push[t] = 1'h0;
    ev[b].pop[t] = 1'h1;
    repeat (cap) @(negedge clk_sys);
    ev[b].pop[t] = 1'h0;
  endtask : t_part

  task automatic t_regs();
    @(negedge clk_sys);
    sched = 16'hffff;
    viol = 2'h2;
    ctx = 1'h1;
    ipl = 2'h1;
    ipn = 32'h0000_1000;
    dfill = 1'h1;
    @(negedge clk_sys);
    chk(sel, 16'h003f);
    chk(cnt, 3'h6);
    chk(flush, 2'h2);
    chk(mode, tps_pkg::CACHE_MODE_ADAPTIVE);
    chk(ip0, 32'h0000_1000);
    sched = 16'h8421;
    viol = 2'h0;
    ctx = 1'h0;
    ipl = 2'h2;
    ipn = 32'h0000_2000;
    dfill = 1'h0;
    @(negedge clk_sys);
    chk(sel, 16'h8421);
    chk(cnt, 3'h4);
    chk(flush, 2'h0);
    chk(mode, tps_pkg::CACHE_MODE_SHARED);
    chk(ip1, 32'h0000_2000);
    chk(ip0, 32'h0000_1000);
    ipl = 2'h0;
    ltid = 1'h1;
    @(negedge clk_sys);
    chk(hit, 1'h0);
    ltid = 1'h0;
    @(negedge clk_sys);
    chk(hit, 1'h1);
  endtask : t_regs

  // Mid-run reset with both stores waiting: thread zero must win first again
  task automatic t_reset();
    @(negedge clk_sys);
    rq[3] = 2'h3;
    @(negedge clk_sys);
    nrst = 1'h0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'h1;
    #1 chk(gn[3], 2'h1);
    chk(ip0, 32'h0000_0000);
    @(negedge clk_sys);
    #1 chk(gn[3], 2'h2);
    @(negedge clk_sys);
    rq[3] = 2'h0;
  endtask : t_reset

  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #(25 * 3000);
    n_errors++;
    test_done();
  end

  initial begin
    nrst = 1'h0;
    {slow, miss, sched, viol, dfill, dftid, ltid, ctx, ipl, ipn} = '0;
    act = 2'h3;
    dvpn = 20'h1a2b3;
    lvpn = 20'h1a2b3;
    rq = '{default: 2'h0};
    ev = '{default: '0};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'h1;
    t_fetch_alt();
    t_miss(1'h0);
    t_miss(1'h1);
    for (int i = 0; i < 4; i++) t_arb(i);
    for (int b = 0; b < 5; b++) begin
      for (int t = 0; t < 2; t++) t_part(b, t, dep[b] / 2);
    end
    act = 2'h1;
    t_part(0, 0, tps_pkg::UOPQ_DEPTH);
    act = 2'h3;
    t_regs();
    t_reset();
    test_done();
  end
endmodule : test_two_thread_pipeline_sharing
`default_nettype wire

// [tps_arb.sv]
// Two-way alternating arbiter used at every thread selection point.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tps_arb (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] req,
  output logic      [1:0] gnt,
  output var logic        prio_q
);

  // Priority thread wins on conflict, lone requester always wins
  always_comb begin
    gnt = 2'h0;
    if (req == 2'h3) begin
      gnt[prio_q] = 1'b1;
    end else begin
      gnt = req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prio_q <= tps_pkg::PRIO_RESET;
    end else if (req == 2'h3) begin
      prio_q <= ~prio_q;
    end
  end

  a_alt_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
    req == 2'h3 |=> prio_q != $past(prio_q))
    else $error("priority did not toggle after contested grant");
  a_lone_full: assert property (@(posedge clk_sys) disable iff (!nrst)
    (req == 2'h1 || req == 2'h2) |-> gnt == req)
    else $error("lone requester not granted");
  a_one_hot: assert property (@(posedge clk_sys) disable iff (!nrst)
    req == 2'h3 |-> gnt == (2'h1 << prio_q))
    else $error("contested grant not given to priority thread");

endmodule : tps_arb
`default_nettype wire

// [tps_core_ctl.sv]
// Sharing control for a two-thread core: arbitration points, partition
// limits, thread-tagged translation lookup and per-thread replicated state.
// Assumes all request and stall inputs come from core logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Partitioned buffers cap each thread at half the entries, except the micro-op queue when only one thread is active.
// - Micro-op queue, rename queues, reorder buffer, load and store buffers are partitioned.
// - Every selection point alternates; a lone able thread gets every cycle.
// - Trace cache fetch arbitrated each clock, alternating when both request.
// - A stalled thread yields full fetch bandwidth until its fill returns.
// - Micro-op queue decouples fetch and rename, partitioned only when both active.
// - Dispatch at most six ready micro-ops per cycle.
// - Dispatch ignores thread identity once micro-ops are queued.
// - Reorder buffer decouples execution and retirement, half per thread.
// - Retirement in program order per thread, alternating threads.
// - A thread with nothing to retire gives all retirement to the other.
// - Store commit into the data cache alternates between threads.
// - Translation entries carry a thread bit; lookups match own entries only.
// - Context bit selects shared or adaptive data cache mode.
// - Architectural state, pointer, rename table, return stack, stream buffer kept per thread.
// - Memory type range registers and performance monitors exist once.
// - Load and store buffers order and check violations per thread.
// - Caches and execution units are fully shared, not partitioned.
module tps_core_ctl #(
  parameter int unsigned UOPQ_DEPTH = tps_pkg::UOPQ_DEPTH,
  parameter int unsigned RNQ_DEPTH  = tps_pkg::RNQ_DEPTH,
  parameter int unsigned ROB_DEPTH  = tps_pkg::ROB_DEPTH,
  parameter int unsigned LDB_DEPTH  = tps_pkg::LDB_DEPTH,
  parameter int unsigned STB_DEPTH  = tps_pkg::STB_DEPTH,
  parameter int unsigned DTB_ENT    = tps_pkg::DTB_ENTRIES,
  parameter int unsigned VPN_W      = tps_pkg::VPN_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic [1:0]           thread_active,
  input  wire logic [1:0]           fetch_req,
  input  wire logic [1:0]           fetch_miss,
  input  wire logic [1:0]           l2_fill_done,
  output logic      [1:0]           fetch_gnt,
  output var logic                  fetch_tid_q,
  output var logic                  fetch_valid_q,
  input  wire tps_pkg::tps_buf_ev_type uopq_ev,
  input  wire tps_pkg::tps_buf_ev_type rnq_ev,
  input  wire tps_pkg::tps_buf_ev_type rob_ev,
  input  wire tps_pkg::tps_buf_ev_type ldb_ev,
  input  wire tps_pkg::tps_buf_ev_type stb_ev,
  output logic      [1:0]           uopq_room,
  output logic      [1:0]           rnq_room,
  output logic      [1:0]           rob_room,
  output logic      [1:0]           ldb_room,
  output logic      [1:0]           stb_room,
  input  wire logic [1:0]           rename_req,
  output logic      [1:0]           rename_gnt,
  input  wire logic [15:0]          sched_ready,
  output var logic  [15:0]          dispatch_sel_q,
  output var logic  [2:0]           dispatch_cnt_q,
  input  wire logic [1:0]           retire_ready,
  output logic      [1:0]           retire_gnt,
  input  wire logic [1:0]           stcommit_req,
  output logic      [1:0]           stcommit_gnt,
  input  wire logic [1:0]           mem_order_viol,
  output var logic  [1:0]           order_flush_q,
  input  wire logic                 dtb_fill,
  input  wire logic                 dtb_fill_tid,
  input  wire logic [VPN_W-1:0]     dtb_fill_vpn,
  input  wire logic                 dtb_look_tid,
  input  wire logic [VPN_W-1:0]     dtb_look_vpn,
  output var logic                  dtb_hit_q,
  input  wire logic                 ctx_id_bit,
  output var logic                  cache_mode_q,
  input  wire logic [1:0]           ip_load,
  input  wire logic [31:0]          ip_new,
  output var logic  [31:0]          ip0_q,
  output var logic  [31:0]          ip1_q
);

  localparam int unsigned CW = tps_pkg::CNT_W;

  // Partition limits
  logic both_active;
  assign both_active = &thread_active;

  tps_pkg::tps_buf_ev_type ev   [5];
  int unsigned              dep  [5];
  logic [1:0]               room [5];
  assign ev[0] = uopq_ev;
  assign ev[1] = rnq_ev;
  assign ev[2] = rob_ev;
  assign ev[3] = ldb_ev;
  assign ev[4] = stb_ev;
  assign dep[0] = UOPQ_DEPTH;
  assign dep[1] = RNQ_DEPTH;
  assign dep[2] = ROB_DEPTH;
  assign dep[3] = LDB_DEPTH;
  assign dep[4] = STB_DEPTH;

  logic [CW-1:0] occ_q [5][2];

  genvar b, t;
  generate
    for (b = 0; b < 5; b++) begin : g_buf
      for (t = 0; t < 2; t++) begin : g_thr
        logic [CW-1:0] lim;
        logic [CW-1:0] tot;
        // Only the micro-op queue grows to full depth for a lone thread
        assign lim = (b == 0 && !both_active) ? CW'(dep[b]) : CW'(dep[b] / 2);
        assign tot = occ_q[b][0] + occ_q[b][1];
        assign room[b][t] = (occ_q[b][t] < lim) && (tot < CW'(dep[b]));
        always_ff @(posedge clk_sys) begin
          if (!nrst) begin
            occ_q[b][t] <= '0;
          end else begin
            // Per-thread count keeps ordering domains apart
            occ_q[b][t] <= occ_q[b][t] + CW'(ev[b].push[t] && room[b][t]) - CW'(ev[b].pop[t]);
          end
        end
        a_half_cap: assert property (@(posedge clk_sys) disable iff (!nrst)
          (b != 0 || both_active) |-> occ_q[b][t] <= CW'(dep[b] / 2))
          else $error("thread exceeded half of partitioned buffer");
      end
    end
  endgenerate

  assign uopq_room = room[0];
  assign rnq_room  = room[1];
  assign rob_room  = room[2];
  assign ldb_room  = room[3];
  assign stb_room  = room[4];

  // Fetch: a missing thread stays out until its fill returns
  logic [1:0] miss_q;
  logic [1:0] fetch_eff;
  assign fetch_eff = fetch_req & ~miss_q & ~fetch_miss & thread_active;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      miss_q <= 2'h0;
    end else begin
      // A new miss outranks a fill landing in the same cycle
      miss_q <= (miss_q & ~l2_fill_done) | fetch_miss;
    end
  end

  logic fetch_prio;
  tps_arb u_fetch_arb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (fetch_eff),
    .gnt     (fetch_gnt),
    .prio_q  (fetch_prio)
  );

  // Thread tag launched with each fetched line
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fetch_valid_q <= 1'b0;
      fetch_tid_q   <= 1'b0;
    end else begin
      fetch_valid_q <= |fetch_gnt;
      fetch_tid_q   <= fetch_gnt[1];
    end
  end

  // Rename takes from the micro-op queue, alternating
  tps_arb u_ren_arb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (rename_req & rnq_room),
    .gnt     (rename_gnt),
    .prio_q  ()
  );

  // Dispatch: first six ready slots, thread blind
  logic [15:0] disp_d;
  logic [2:0]  disp_n;
  always_comb begin
    disp_d = 16'h0000;
    disp_n = 3'h0;
    for (int i = 0; i < 16; i++) begin
      if (sched_ready[i] && disp_n < 3'(tps_pkg::DISPATCH_MAX)) begin
        disp_d[i] = 1'b1;
        disp_n    = disp_n + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dispatch_sel_q <= 16'h0000;
      dispatch_cnt_q <= 3'h0;
    end else begin
      dispatch_sel_q <= disp_d;
      dispatch_cnt_q <= disp_n;
    end
  end

  a_disp_max: assert property (@(posedge clk_sys) disable iff (!nrst)
    dispatch_cnt_q <= 3'(tps_pkg::DISPATCH_MAX))
    else $error("more than six micro-ops dispatched");
  a_disp_ready: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dispatch_sel_q & ~$past(sched_ready)) == 16'h0000)
    else $error("dispatched a micro-op that was not ready");
  a_disp_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    $countones(dispatch_sel_q) == int'(dispatch_cnt_q))
    else $error("dispatch count disagrees with selection");

  // Retirement, oldest-first per thread handled by the reorder buffer
  logic ret_prio;
  tps_arb u_ret_arb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (retire_ready),
    .gnt     (retire_gnt),
    .prio_q  (ret_prio)
  );

  a_ret_lone: assert property (@(posedge clk_sys) disable iff (!nrst)
    retire_ready == 2'h2 |-> retire_gnt == 2'h2)
    else $error("lone retiring thread starved");
  a_ret_alt: assert property (@(posedge clk_sys) disable iff (!nrst)
    (retire_ready == 2'h3) ##1 (retire_ready == 2'h3) |-> retire_gnt != $past(retire_gnt))
    else $error("retirement did not alternate");

  // Store commit into the data cache
  tps_arb u_st_arb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .req     (stcommit_req),
    .gnt     (stcommit_gnt),
    .prio_q  ()
  );

  a_st_first: assert property (@(posedge clk_sys)
    $rose(nrst) && stcommit_req == 2'h3 |-> stcommit_gnt == 2'h1)
    else $error("thread zero not favoured after reset");

  // Ordering violation flushes only the offending thread
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      order_flush_q <= 2'h0;
    end else begin
      order_flush_q <= mem_order_viol;
    end
  end

  // Thread-tagged translation buffer, round-robin fill
  logic [VPN_W-1:0]           dtb_vpn_q [DTB_ENT];
  logic [DTB_ENT-1:0]         dtb_val_q;
  logic [DTB_ENT-1:0]         dtb_tid_q;
  logic [$clog2(DTB_ENT)-1:0] dtb_ptr_q;
  logic                       hit_d;

  always_comb begin
    hit_d = 1'b0;
    for (int i = 0; i < DTB_ENT; i++) begin
      if (dtb_val_q[i] && dtb_tid_q[i] == dtb_look_tid && dtb_vpn_q[i] == dtb_look_vpn) begin
        hit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dtb_val_q <= '0;
      dtb_tid_q <= '0;
      dtb_ptr_q <= '0;
      dtb_hit_q <= 1'b0;
    end else begin
      dtb_hit_q <= hit_d;
      if (dtb_fill) begin
        dtb_val_q[dtb_ptr_q] <= 1'b1;
        dtb_tid_q[dtb_ptr_q] <= dtb_fill_tid;
        dtb_ptr_q            <= dtb_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dtb_fill) begin
      dtb_vpn_q[dtb_ptr_q] <= dtb_fill_vpn;
    end
  end

  // Cache mode from the context bit cache itself stays shared
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cache_mode_q <= tps_pkg::CACHE_MODE_SHARED;
    end else begin
      cache_mode_q <= ctx_id_bit ? tps_pkg::CACHE_MODE_ADAPTIVE : tps_pkg::CACHE_MODE_SHARED;
    end
  end

  // Per-thread instruction pointer copy range and perf registers live outside, once
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ip0_q <= 32'h0000_0000;
      ip1_q <= 32'h0000_0000;
    end else begin
      if (ip_load[0]) begin
        ip0_q <= ip_new;
      end
      if (ip_load[1]) begin
        ip1_q <= ip_new;
      end
    end
  end

  a_ip_isolate: assert property (@(posedge clk_sys) disable iff (!nrst)
    ip_load == 2'h1 |=> ip1_q == $past(ip1_q))
    else $error("thread one pointer disturbed by thread zero load");
  a_miss_block: assert property (@(posedge clk_sys) disable iff (!nrst)
    miss_q[0] |-> !fetch_gnt[0])
    else $error("missing thread granted fetch");
  a_fetch_full: assert property (@(posedge clk_sys) disable iff (!nrst)
    miss_q[0] && fetch_eff[1] |-> fetch_gnt[1])
    else $error("other thread lost bandwidth during miss");
  a_miss_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    fetch_miss[0] |=> miss_q[0])
    else $error("new miss lost to a fill in the same cycle");
  a_fetch_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
    fetch_eff == 2'h3 |-> fetch_gnt[fetch_prio])
    else $error("contested fetch not given to priority thread");
  a_ret_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
    retire_ready == 2'h3 |=> ret_prio != $past(ret_prio))
    else $error("retire priority did not alternate");
  a_flush_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> order_flush_q == $past(mem_order_viol))
    else $error("ordering flush not raised for offending thread");
  a_mode_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> cache_mode_q == $past(ctx_id_bit))
    else $error("cache mode does not follow context bit");

  c_fetch_alt: cover property (@(posedge clk_sys) disable iff (!nrst)
    fetch_gnt == 2'h1 ##1 fetch_gnt == 2'h2);
  c_ret_lone:  cover property (@(posedge clk_sys) disable iff (!nrst) retire_gnt == 2'h2 && retire_ready == 2'h2);
  c_disp_six:  cover property (@(posedge clk_sys) disable iff (!nrst) dispatch_cnt_q == 3'h6);
  c_dtb_hit:   cover property (@(posedge clk_sys) disable iff (!nrst) dtb_hit_q);

endmodule : tps_core_ctl
`default_nettype wire

// [tps_l2_model.sv]
// Far-side model of the second-level cache that answers trace cache misses.
// Assumes fetch_miss pulses on clk_sys; the fill comes back after LAT cycles, or three times that when slow is set.
`timescale 1ns/1ps
`default_nettype none
module tps_l2_model #(
  parameter int unsigned LAT = 5
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic [1:0] fetch_miss,
  output var logic  [1:0] l2_fill_done
);
  int unsigned wait_q [2];

  // Slow mode triples the wait so a long stall is seen as well as a short one
  always_ff @(posedge clk_sys) begin
    for (int t = 0; t < 2; t++) begin
      l2_fill_done[t] <= 1'h0;
      if (!nrst) begin
        wait_q[t] <= 0;
      end else if (fetch_miss[t]) begin
        wait_q[t] <= slow ? 3 * LAT : LAT;
      end else if (wait_q[t] == 1) begin
        wait_q[t]       <= 0;
        l2_fill_done[t] <= 1'h1;
      end else if (wait_q[t] != 0) begin
        wait_q[t] <= wait_q[t] - 1;
      end
    end
  end
endmodule : tps_l2_model
`default_nettype wire

// [tps_pkg.sv]
// Shared types and constants for the two-thread pipeline sharing control.
// Assumes a single core clock; thread 0 and thread 1 contexts sit in the same core.
package tps_pkg;

  localparam int unsigned UOPQ_DEPTH     = 16;
  localparam int unsigned RNQ_DEPTH      = 16;
  localparam int unsigned ROB_DEPTH      = 32;
  localparam int unsigned LDB_DEPTH      = 16;
  localparam int unsigned STB_DEPTH      = 16;
  localparam int unsigned DISPATCH_MAX   = 6;
  localparam int unsigned STREAM_BUF_ENT = 2;
  localparam int unsigned CNT_W          = 6;
  localparam int unsigned DTB_ENTRIES    = 8;
  localparam int unsigned VPN_W          = 20;
  localparam logic        PRIO_RESET     = 1'b0;

  // L1 data cache mode selected by the context identifier bit
  localparam logic CACHE_MODE_SHARED   = 1'b0;
  localparam logic CACHE_MODE_ADAPTIVE = 1'b1;

  // One staging buffer's per-thread push/pop strobes
  typedef struct packed {
    logic [1:0] push;
    logic [1:0] pop;
  } tps_buf_ev_type;

  // Micro-op tag carried through the pipe
  typedef struct packed {
    logic       valid;
    logic       tid;
  } tps_uop_tag_type;

endpackage : tps_pkg
